// File: core/bin_sort_defines.vh
// Constants for the bin sorting comparator: register map, fields, codes and reset values.
`ifndef BIN_SORT_DEFINES_VH
`define BIN_SORT_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets; the bin table base is given as address bits 7:6
// ----------------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_NOMINAL 8'h04
`define OFS_ENTRY 8'h08
`define OFS_STATUS 8'h0C
`define OFS_SEC_LO 8'h10
`define OFS_SEC_HI 8'h14
`define OFS_BIN_BASE 2'h1

// ----------------------------------------------------------------
// Control and status fields
// ----------------------------------------------------------------
`define CTRL_ON 0
`define CTRL_AUX 1
`define CTRL_SWAP 2
`define CTRL_MODE_LO 3
`define CTRL_CABLE_LO 5
`define CTRL_CLEAR 8
`define STAT_BUSY 4
`define STAT_WARN 5

// ----------------------------------------------------------------
// Limit modes, cable codes, outcome codes, percent scale, last bin and entry cursor slots
// ----------------------------------------------------------------
`define MODE_ABS 2'h0
`define MODE_PCT 2'h1
`define MODE_SEQ 2'h2
`define CABLE_0M 2'h0
`define CABLE_1M 2'h1
`define CABLE_2M 2'h2
`define CABLE_4M 2'h3
`define OUT_NONE 4'h0
`define OUT_AUX 4'h9
`define OUT_REJECT 4'hA
`define PCT_SCALE 66'sh64
`define LAST_BIN 3'h7
`define CUR_TOL_SLO 4'h8
`define CUR_TOL_SHI 4'h9
`define CUR_SEQ_SLO 4'h9
`define CUR_SEQ_SHI 4'hA

// ----------------------------------------------------------------
// Reset values and bus answers
// ----------------------------------------------------------------
`define RST_MODE `MODE_ABS
`define RST_CABLE `CABLE_0M
`define RST_LIMIT 32'h00000000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: core/bin_sort.v
// Result sorting comparator with limit table, AXI4-Lite registers and sorter outputs.
`timescale 1ns/1ps
`include "bin_sort_defines.vh"
// What this block does
// - Cable length selectable: 0, 1, 2, 4 m.
// - Outcomes: bins one to eight, aux, or reject.
// - Eight primary limit pairs, one secondary pair.
// - Swap exchanges primary and secondary measured values.
// - Tolerance limits are deviations from nominal value.
// - Ordered mode: absolute ascending ranges, entered ascending.
// - Bins tested ascending; first match wins.
// - Tolerance ranges may overlap, gap, straddle freely.
// - Three modes: absolute, percent, ordered range.
// - Nominal ignored in ordered-range mode.
// - Sorting happens only while comparator is on.
// - Aux off: secondary outside limits means reject.
// - Aux on: primary fail rejects, secondary fail aux.
// - Lower above upper: warn, skip bin, continue.
// - Tolerance entry: one magnitude sets minus/plus limits.
// - Ordered entry: next lower copies previous upper.
// - Entry advances bins, secondary lower, secondary upper.
// - Clear command zeroes every stored limit.
// - Each result is driven on sorter outputs.

module bin_sort (
	input wire clk, // 20 MHz clock
	input wire rst, // asynchronous reset, active high
	input wire [7:0] s_axi_awaddr, // write address
	input wire s_axi_awvalid, // write address valid
	output reg s_axi_awready, // write address ready
	input wire [31:0] s_axi_wdata, // write data
	input wire [3:0] s_axi_wstrb, // write byte strobes
	input wire s_axi_wvalid, // write data valid
	output reg s_axi_wready, // write data ready
	output reg [1:0] s_axi_bresp, // write response
	output reg s_axi_bvalid, // write response valid
	input wire s_axi_bready, // write response ready
	input wire [7:0] s_axi_araddr, // read address
	input wire s_axi_arvalid, // read address valid
	output reg s_axi_arready, // read address ready
	output reg [31:0] s_axi_rdata, // read data
	output reg [1:0] s_axi_rresp, // read response
	output reg s_axi_rvalid, // read data valid
	input wire s_axi_rready, // read data ready
	input wire meas_valid, // one-cycle pulse: measurement finished
	input wire [31:0] meas_primary, // signed primary value
	input wire [31:0] meas_secondary, // signed secondary value
	output reg [7:0] sort_bin, // one-hot graded bin
	output reg sort_aux, // auxiliary bin
	output reg reject_outcome, // reject bin
	output reg sort_strobe, // one-cycle pulse: new result
	output reg [1:0] cable_len // cable length code
);

	localparam ST_IDLE = 3'h1;
	localparam ST_SCAN = 3'h2;
	localparam ST_DONE = 3'h4;

	// ----------------------------------------------------------------
	// Configuration and state
	// ----------------------------------------------------------------
	reg comp_on_r;
	reg aux_en_r;
	reg swap_r;
	reg [1:0] mode_r;
	reg signed [31:0] nominal_r;
	reg signed [31:0] sec_lo_r;
	reg signed [31:0] sec_hi_r;
	reg signed [31:0] lo_r [0:7];
	reg signed [31:0] hi_r [0:7];
	reg [3:0] cur_r;
	reg warn_r;
	reg [3:0] outcome_r;
	reg [2:0] st_r;
	reg [2:0] idx_r;
	reg [2:0] hitbin_r;
	reg hit_r;
	reg signed [31:0] m_r;
	reg signed [31:0] s_r;

	reg aw_full_r;
	reg w_full_r;
	reg [7:0] waddr_r;
	reg [31:0] wdata_r;
	reg [3:0] wstrb_r;

	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] strb;
		integer k;
		begin
			for (k = 0; k < 4; k = k + 1) begin
				merge[8*k +: 8] = strb[k] ? nw[8*k +: 8] : old[8*k +: 8];
			end
		end
	endfunction

	// ----------------------------------------------------------------
	// Write decode
	// ----------------------------------------------------------------
	wire wr_go = aw_full_r & w_full_r & ~s_axi_bvalid;
	wire wr_bin = (waddr_r[7:6] == `OFS_BIN_BASE);
	wire [31:0] ctrl_rd = {23'h000000, 1'b0, 1'b0, cable_len, mode_r, swap_r, aux_en_r, comp_on_r};
	wire [31:0] ctrl_new = merge(ctrl_rd, wdata_r, wstrb_r);
	wire wr_ctrl = wr_go & (waddr_r == `OFS_CTRL);
	wire clr = wr_ctrl & ctrl_new[`CTRL_CLEAR];
	wire ent = wr_go & (waddr_r == `OFS_ENTRY);
	wire seq_mode = (mode_r != `MODE_ABS) && (mode_r != `MODE_PCT);
	wire [3:0] cur_last = seq_mode ? `CUR_SEQ_SHI : `CUR_TOL_SHI;
	wire [3:0] cur_slo = seq_mode ? `CUR_SEQ_SLO : `CUR_TOL_SLO;
	wire signed [31:0] ent_neg = -wdata_r;
	wire wr_map = (waddr_r == `OFS_CTRL) || (waddr_r == `OFS_NOMINAL) ||
		(waddr_r == `OFS_ENTRY) || (waddr_r == `OFS_STATUS) ||
		(waddr_r == `OFS_SEC_LO) || (waddr_r == `OFS_SEC_HI) ||
		(wr_bin && (waddr_r[1:0] == 2'h0));

	// ----------------------------------------------------------------
	// Evaluation of the bin under test
	// ----------------------------------------------------------------
	wire signed [31:0] cl = lo_r[idx_r];
	wire signed [31:0] ch = hi_r[idx_r];
	wire signed [65:0] m66 = {{34{m_r[31]}}, m_r};
	wire signed [65:0] n66 = {{34{nominal_r[31]}}, nominal_r};
	wire signed [65:0] cl66 = {{34{cl[31]}}, cl};
	wire signed [65:0] ch66 = {{34{ch[31]}}, ch};
	wire signed [65:0] dm = m66 - n66;
	wire bad = (cl > ch);
	wire sec_in = (s_r >= sec_lo_r) && (s_r <= sec_hi_r);
	reg signed [65:0] mx;
	reg signed [65:0] lox;
	reg signed [65:0] hix;
	reg inr;

	always @* begin
		mx = m66;
		lox = cl66;
		hix = ch66;
		inr = 1'b0;
		case (mode_r)
			`MODE_ABS: begin
				mx = dm;
			end
			`MODE_PCT: begin
				// Cross-multiplied so no divider is needed and no quotient is truncated.
				mx = dm * `PCT_SCALE;
				lox = cl66 * n66;
				hix = ch66 * n66;
			end
			default: begin
				mx = m66;
			end
		endcase
		if (mode_r == `MODE_PCT && nominal_r == 32'h00000000) begin
			inr = 1'b0;
		end else if (mode_r == `MODE_PCT && nominal_r[31]) begin
			inr = (mx <= lox) && (mx >= hix);
		end else begin
			inr = (mx >= lox) && (mx <= hix);
		end
	end

	wire match = ~bad & inr;

	// ----------------------------------------------------------------
	// Limit table, one slot per bin
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_bin
			wire d_lo = wr_go & wr_bin & (waddr_r[5:3] == gi) & ~waddr_r[2];
			wire d_hi = wr_go & wr_bin & (waddr_r[5:3] == gi) & waddr_r[2];
			always @(posedge clk or posedge rst) begin
				if (rst) begin
					lo_r[gi] <= `RST_LIMIT;
					hi_r[gi] <= `RST_LIMIT;
				end else if (clr) begin
					lo_r[gi] <= `RST_LIMIT;
					hi_r[gi] <= `RST_LIMIT;
				end else if (ent && !seq_mode) begin
					if (cur_r == gi) begin
						lo_r[gi] <= ent_neg;
						hi_r[gi] <= wdata_r;
					end
				end else if (ent && seq_mode) begin
					if (cur_r == gi) begin
						lo_r[gi] <= wdata_r;
					end
					if (cur_r == gi + 1) begin
						hi_r[gi] <= wdata_r;
					end
				end else begin
					if (d_lo) begin
						lo_r[gi] <= merge(lo_r[gi], wdata_r, wstrb_r);
					end
					if (d_hi) begin
						hi_r[gi] <= merge(hi_r[gi], wdata_r, wstrb_r);
					end
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Configuration registers and the entry cursor
	// ----------------------------------------------------------------
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			comp_on_r <= 1'b0;
			aux_en_r <= 1'b0;
			swap_r <= 1'b0;
			mode_r <= `RST_MODE;
			cable_len <= `RST_CABLE;
			nominal_r <= `RST_LIMIT;
			sec_lo_r <= `RST_LIMIT;
			sec_hi_r <= `RST_LIMIT;
			cur_r <= 4'h0;
		end else begin
			if (wr_ctrl) begin
				comp_on_r <= ctrl_new[`CTRL_ON];
				aux_en_r <= ctrl_new[`CTRL_AUX];
				swap_r <= ctrl_new[`CTRL_SWAP];
				mode_r <= ctrl_new[`CTRL_MODE_LO +: 2];
				cable_len <= ctrl_new[`CTRL_CABLE_LO +: 2];
			end
			if (wr_go && waddr_r == `OFS_NOMINAL) begin
				nominal_r <= merge(nominal_r, wdata_r, wstrb_r);
			end
			if (clr) begin
				sec_lo_r <= `RST_LIMIT;
				sec_hi_r <= `RST_LIMIT;
				cur_r <= 4'h0;
			end else if (ent) begin
				if (cur_r == cur_slo) begin
					sec_lo_r <= wdata_r;
				end
				if (cur_r == cur_last) begin
					sec_hi_r <= wdata_r;
				end
				cur_r <= (cur_r >= cur_last) ? 4'h0 : cur_r + 4'h1;
			end else begin
				if (wr_go && waddr_r == `OFS_SEC_LO) begin
					sec_lo_r <= merge(sec_lo_r, wdata_r, wstrb_r);
				end
				if (wr_go && waddr_r == `OFS_SEC_HI) begin
					sec_hi_r <= merge(sec_hi_r, wdata_r, wstrb_r);
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Sorting sequence
	// ----------------------------------------------------------------
	// A measurement that arrives while a scan is running is dropped, so limits are
	// never mixed between two parts.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r <= ST_IDLE;
			idx_r <= 3'h0;
			hit_r <= 1'b0;
			hitbin_r <= 3'h0;
			m_r <= 32'h00000000;
			s_r <= 32'h00000000;
			warn_r <= 1'b0;
			outcome_r <= `OUT_NONE;
			sort_bin <= 8'h00;
			sort_aux <= 1'b0;
			reject_outcome <= 1'b0;
			sort_strobe <= 1'b0;
		end else begin
			sort_strobe <= 1'b0;
			if (wr_go && waddr_r == `OFS_STATUS && wstrb_r[0] && wdata_r[`STAT_WARN]) begin
				warn_r <= 1'b0;
			end
			if ((st_r == ST_SCAN) && bad) begin
				warn_r <= 1'b1;
			end
			case (st_r)
				ST_IDLE: begin
					if (meas_valid && comp_on_r) begin
						m_r <= swap_r ? meas_secondary : meas_primary;
						s_r <= swap_r ? meas_primary : meas_secondary;
						idx_r <= 3'h0;
						st_r <= ST_SCAN;
					end else if (meas_valid) begin
						outcome_r <= `OUT_NONE;
						sort_bin <= 8'h00;
						sort_aux <= 1'b0;
						reject_outcome <= 1'b0;
					end
				end
				ST_SCAN: begin
					if (match) begin
						hit_r <= 1'b1;
						hitbin_r <= idx_r;
						st_r <= ST_DONE;
					end else if (idx_r == `LAST_BIN) begin
						hit_r <= 1'b0;
						st_r <= ST_DONE;
					end else begin
						idx_r <= idx_r + 3'h1;
					end
				end
				ST_DONE: begin
					sort_strobe <= 1'b1;
					sort_bin <= 8'h00;
					sort_aux <= 1'b0;
					reject_outcome <= 1'b0;
					st_r <= ST_IDLE;
					if (!hit_r || (!aux_en_r && !sec_in)) begin
						reject_outcome <= 1'b1;
						outcome_r <= `OUT_REJECT;
					end else if (!sec_in) begin
						sort_aux <= 1'b1;
						outcome_r <= `OUT_AUX;
					end else begin
						sort_bin <= 8'h01 << hitbin_r;
						outcome_r <= {1'b0, hitbin_r} + 4'h1;
					end
				end
				default: begin
					st_r <= ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------------------------------
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			aw_full_r <= 1'b0;
			w_full_r <= 1'b0;
			waddr_r <= 8'h00;
			wdata_r <= 32'h00000000;
			wstrb_r <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				waddr_r <= {s_axi_awaddr[7:2], 2'h0};
				aw_full_r <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
				w_full_r <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_map ? `RESP_OKAY : `RESP_SLVERR;
				aw_full_r <= 1'b0;
				w_full_r <= 1'b0;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------------------------------
	wire [7:0] ra = {s_axi_araddr[7:2], 2'h0};
	wire busy = (st_r != ST_IDLE);
	reg [31:0] rd_mux;
	reg rd_ok;

	always @* begin
		rd_mux = 32'h00000000;
		rd_ok = 1'b1;
		if (ra[7:6] == `OFS_BIN_BASE) begin
			rd_mux = ra[2] ? hi_r[ra[5:3]] : lo_r[ra[5:3]];
		end else begin
			case (ra)
				`OFS_CTRL: rd_mux = ctrl_rd;
				`OFS_NOMINAL: rd_mux = nominal_r;
				`OFS_ENTRY: rd_mux = {28'h0000000, cur_r};
				`OFS_STATUS: rd_mux = {26'h0000000, warn_r, busy, outcome_r};
				`OFS_SEC_LO: rd_mux = sec_lo_r;
				`OFS_SEC_HI: rd_mux = sec_hi_r;
				default: rd_ok = 1'b0;
			endcase
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
				s_axi_rvalid <= 1'b1;
				s_axi_arready <= 1'b0;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule // bin_sort

// File: tb/bin_sort_properties.sv
// Concurrent checks on the bin sorting comparator ports.
`timescale 1ns/1ps
module bin_sort_properties (
	input wire clk, // clock
	input wire rst, // reset
	input wire s_axi_awvalid, // write address valid
	input wire s_axi_awready, // write address ready
	input wire s_axi_wvalid, // write data valid
	input wire s_axi_wready, // write data ready
	input wire s_axi_bvalid, // write response valid
	input wire s_axi_arvalid, // read address valid
	input wire s_axi_arready, // read address ready
	input wire s_axi_rvalid, // read data valid
	input wire s_axi_rready, // read data ready
	input wire [31:0] s_axi_rdata, // read data
	input wire meas_valid, // measurement finished
	input wire sort_aux, // auxiliary bin
	input wire reject_outcome, // reject bin
	input wire sort_strobe, // new result
	input wire [7:0] sort_bin, // graded bins
	input wire [1:0] cable_len // cable code
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_strobe_pulse: assert property (sort_strobe |=> !sort_strobe)
		else $error("strobe too long");
	a_single_outcome: assert property (sort_strobe |-> $onehot({sort_bin, sort_aux, reject_outcome}))
		else $error("outcome not unique");
	// An off-state clear follows a measurement without a strobe, so those cycles are excused.
	a_result_held: assert property (!sort_strobe && !$past(meas_valid) && !$past(meas_valid, 2)
		|-> $stable({sort_bin, sort_aux, reject_outcome}))
		else $error("result moved");
	a_cable_write: assert property ($changed(cable_len) |-> !s_axi_wready)
		else $error("cable moved outside a write");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##2 s_axi_bvalid)
		else $error("write answer late");
	a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answering");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_read_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
endmodule // bin_sort_properties
bind bin_sort bin_sort_properties u_bin_sort_properties (.*);

// File: tb/sort_handler.sv
// Handler model that reads the sorter lines and counts results.
`timescale 1ns/1ps
module sort_handler (
	input wire clk, // clock
	input wire rst, // reset
	input wire [7:0] sort_bin, // graded bins
	input wire sort_aux, // auxiliary bin
	input wire reject_outcome, // reject bin
	input wire sort_strobe, // new result
	output logic [3:0] code, // outcome seen
	output int n_seen // results taken
);
	always_comb begin
		code = reject_outcome ? 4'hA : sort_aux ? 4'h9 : 4'h0;
		for (int i = 0; i < 8; i++) if (sort_bin[i]) code = 4'(i + 1);
	end
	always @(posedge clk or posedge rst) begin
		if (rst) n_seen <= 0;
		else if (sort_strobe) n_seen <= n_seen + 1;
	end
endmodule // sort_handler

// File: tb/test_bin_sort.sv
// Self-checking bench for the bin sorting comparator.
`timescale 1ns/1ps
module test_bin_sort;
	logic clk = 0, rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, meas_valid = 0, aux, swp, wm;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, meas_primary = 32'h0, meas_secondary = 32'h0, rv;
	logic [3:0] s_axi_wstrb = 4'hF, lst;
	logic [1:0] md, cab, rr, br;
	logic signed [31:0] nom, slo, shi, lo [8], hi [8], ent [11];
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire sort_aux, reject_outcome, sort_strobe;
	wire [1:0] s_axi_bresp, s_axi_rresp, cable_len;
	wire [31:0] s_axi_rdata;
	wire [7:0] sort_bin;
	wire [3:0] code;
	int n_seen, error_cnt = 0, n_tests = 0, n_exp = 0;
	bin_sort u_bin_sort (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .meas_valid, .meas_primary,
		.meas_secondary, .sort_bin, .sort_aux, .reject_outcome, .sort_strobe, .cable_len);
	sort_handler u_sort_handler (.clk, .rst, .sort_bin, .sort_aux, .reject_outcome,
		.sort_strobe, .code, .n_seen);
	initial forever #25 clk = ~clk;
	task automatic wrap_up;
		if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tmo(input logic ok);
		if (!ok) begin
			error_cnt++;
			$display("[ERR] %0t bus wait ran out", $time);
			wrap_up();
		end
	endtask
	// Ready is sampled at the falling edge, where it already equals its value at the next rise.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		int k;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		tb = 0;
		for (k = 0; !tb && k < 40; k++) begin
			@(negedge clk);
			ta = s_axi_awready;
			tw = s_axi_wready;
			tb = s_axi_bvalid;
			br = s_axi_bresp;
			@(posedge clk);
			if (ta) s_axi_awvalid <= 0;
			if (tw) s_axi_wvalid <= 0;
		end
		s_axi_bready <= 0;
		tmo(tb);
	endtask
	// Ready for the read answer comes one cycle late so the answer has to stand.
	task automatic rd(input logic [7:0] a);
		logic ta, tr;
		int k;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		tr = 0;
		for (k = 0; !tr && k < 40; k++) begin
			@(negedge clk);
			ta = s_axi_arready & s_axi_arvalid;
			tr = s_axi_rvalid & s_axi_rready;
			rv = s_axi_rdata;
			rr = s_axi_rresp;
			@(posedge clk);
			if (ta) s_axi_arvalid <= 0;
			else if (!s_axi_arvalid && !tr) s_axi_rready <= 1;
		end
		s_axi_rready <= 0;
		tmo(tr);
	endtask
	function automatic logic [3:0] grade(input logic signed [31:0] p, input logic signed [31:0] s);
		logic signed [31:0] t;
		logic signed [65:0] d, l, h;
		logic ok;
		grade = 4'hA;
		if (swp) begin
			t = p;
			p = s;
			s = t;
		end
		for (int j = 7; j >= 0; j--) begin
			d = (md == 2'h0) ? p - nom : (md == 2'h1) ? (p - nom) * 100 : p;
			l = (md == 2'h1) ? lo[j] * nom : lo[j];
			h = (md == 2'h1) ? hi[j] * nom : hi[j];
			if (md == 2'h1 && nom < 0) {l, h} = {h, l};
			ok = d >= l && d <= h && !(md == 2'h1 && nom == 0) && lo[j] <= hi[j];
			if (ok) grade = 4'(j + 1);
		end
		for (int j = 0; j < 8; j++) if (lo[j] > hi[j] && j + 1 < grade) wm = 1;
		ok = s >= slo && s <= shi;
		if (!ok && (grade != 4'hA || !aux)) grade = aux ? 4'h9 : 4'hA;
	endfunction
	task automatic ms(input logic signed [31:0] p, input logic signed [31:0] s, input logic on);
		logic st;
		int k;
		@(posedge clk);
		meas_valid <= 1;
		meas_primary <= p;
		meas_secondary <= s;
		@(posedge clk);
		meas_valid <= 0;
		st = 0;
		for (k = 0; !st && k < 20; k++) begin
			@(negedge clk);
			st = sort_strobe;
		end
		lst = on ? grade(p, s) : 4'h0;
		chk(st, on);
		chk(code, lst);
		n_exp += on;
	endtask
	task automatic cfg(input logic on, input logic clr);
		wr(8'h00, {23'h0, clr, 1'b0, cab, md, swp, aux, on});
	endtask
	initial begin
		int c;
		void'($urandom(32'h5A628B3F));
		aux = 0;
		swp = 0;
		md = 2'h0;
		repeat (20) @(posedge clk);
		rst <= 0;
		rd(8'h00);
		chk(rv, 32'h0);
		rd(8'h0C);
		chk(rv, 32'h0);
		rd(8'h30);
		chk(rr, 2'h2);
		wr(8'h30, 32'h1);
		chk(br, 2'h2);
		for (c = 0; c < 4; c++) begin
			cab = 2'(c);
			cfg(0, 0);
			chk(cable_len, cab);
			chk(br, 2'h0);
		end
		// Each mode is run with aux off and on, then all again with swap.
		// The swapped half runs ordered mode under its spare code instead.
		for (c = 0; c < 24; c++) begin
			md = 2'(c % 3);
			if (c >= 12 && md == 2'h2) md = 2'h3;
			aux = (c / 3) % 2;
			swp = c >= 12;
			nom = $urandom_range(1, 50);
			if (c % 2) nom = -nom;
			cfg(1, 1);
			for (int j = 0; j < 8; j++) begin
				lo[j] = md[1] ? (j ? hi[j - 1] : -150) : $signed($urandom_range(0, 200)) - 100;
				hi[j] = md[1] ? lo[j] + $urandom_range(0, 40) : $signed($urandom_range(0, 200)) - 100;
				if (j == 2 && c % 4 == 3) lo[j] = hi[j] + 5;
				wr(8'h40 + 8'(8 * j), lo[j]);
				wr(8'h44 + 8'(8 * j), hi[j]);
			end
			slo = -$urandom_range(0, 100);
			shi = $urandom_range(0, 100);
			wr(8'h10, slo);
			wr(8'h14, shi);
			wr(8'h04, nom);
			wm = 0;
			repeat (8) ms($signed($urandom_range(0, 300)) - 150, $signed($urandom_range(0, 300)) - 150, 1);
			rd(8'h0C);
			chk(rv[5:0], {wm, 1'b0, lst});
			wr(8'h0C, 32'h20);
		end
		cfg(0, 0);
		ms(5, 5, 0);
		for (int m = 0; m < 2; m++) begin
			md = m ? 2'h2 : 2'h0;
			cfg(1, 1);
			rd(8'h58);
			chk(rv, 32'h0);
			for (c = 0; c < 10 + m; c++) begin
				ent[c] = $urandom_range(1, 999);
				wr(8'h08, ent[c]);
			end
			for (c = 0; c < 8; c++) begin
				rd(8'h40 + 8'(8 * c));
				chk(rv, m ? ent[c] : -ent[c]);
				rd(8'h44 + 8'(8 * c));
				chk(rv, ent[c + m]);
			end
			rd(8'h10);
			chk(rv, ent[8 + m]);
			rd(8'h14);
			chk(rv, ent[9 + m]);
			rd(8'h08);
			chk(rv[3:0], 4'h0);
		end
		chk(n_seen, n_exp);
		wrap_up();
	end
endmodule // test_bin_sort
